// ### tmn_avg.sv
// Averager for one sensor: sums 4, 8, 16 or 32 signed samples, emits mean.
// Assumes samples arrive as one-cycle strobes with 12-bit signed data.
module tmn_avg #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         run,
	input  wire logic [1:0]   sel,
	// Samples in
	input  wire logic         smp_vld,
	input  wire logic [W-1:0] smp,
	// Averaged result out
	output logic              avg_vld,
	output logic [W-1:0]      avg
);
	logic [W+4:0] acc_reg;  // Running sum, five extra bits for 32 samples
	logic [4:0]   cnt_reg;  // Samples taken so far in this average
	logic [4:0]   last;     // Final count for the chosen depth
	logic         done;     // This sample closes the average
	logic [W+4:0] sum;      // Sum including this sample

	assign last = 5'((5'h4 << sel) - 5'h1);
	// Greater-or-equal so a depth lowered mid-average still closes it
	assign done = smp_vld && (cnt_reg >= last);
	assign sum  = acc_reg + {{5{smp[W-1]}}, smp};

	// Accumulate; a disabled monitor holds no partial average (R13)
	always_ff @(posedge clk)
	begin
		if (srst || !run)
		begin
			acc_reg <= '0;
			cnt_reg <= '0;
			avg_vld <= 1'b0;
			avg     <= '0;
		end
		else
		begin
			avg_vld <= done;
			if (done)
			begin
				// Arithmetic shift gives the mean; rounds toward minus infinity
				// Shift amount widened so depth codes 10 and 11 do not wrap
				avg     <= W'($signed(sum) >>> (3'(sel) + 3'd2)); // R1 R2 R3
				acc_reg <= '0;
				cnt_reg <= '0;
			end
			else if (smp_vld)
			begin
				acc_reg <= sum;
				cnt_reg <= cnt_reg + 5'h1;
			end
		end
	end

	AST_COUNT_BOUND: assert property (@(posedge clk) disable iff (srst)
		cnt_reg <= last || $changed(sel)) // R13
		else $error("sample count passed the chosen depth");
	COV_AVG: cover property (@(posedge clk) disable iff (srst) avg_vld);
endmodule : tmn_avg

// ### tmn_cmp.sv
// Signed threshold compare for one sensor, updated once per average.
// Assumes averages arrive as one-cycle strobes.
module tmn_cmp #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Control
	input  wire logic         run,
	input  wire logic [W-1:0] hi_lim,
	input  wire logic [W-1:0] lo_lim,
	// Average in
	input  wire logic         avg_vld,
	input  wire logic [W-1:0] avg,
	// Alarm flags
	output logic              hi_flag,
	output logic              lo_flag
);
	logic above; // Signed compare against high limit
	logic below; // Signed compare against low limit

	assign above = $signed(avg) > $signed(hi_lim); // R10
	assign below = $signed(avg) < $signed(lo_lim); // R10

	// Flags follow each new average, cleared while stopped
	always_ff @(posedge clk)
	begin
		if (srst || !run)
		begin
			hi_flag <= 1'b0; // R14
			lo_flag <= 1'b0; // R14
		end
		else if (avg_vld)
		begin
			hi_flag <= above; // R4 R6 R8 R13
			lo_flag <= below; // R5 R7 R9 R13
		end
	end

	AST_HI_FLAG: assert property (@(posedge clk) disable iff (srst)
		run && avg_vld && $signed(avg) > $signed(hi_lim) ##1 run |-> hi_flag) // R4
		else $error("high alarm missed");
	AST_LO_FLAG: assert property (@(posedge clk) disable iff (srst)
		run && avg_vld && $signed(avg) >= $signed(lo_lim) ##1 run |-> !lo_flag) // R5
		else $error("low alarm set wrongly");
	AST_STOP_CLR: assert property (@(posedge clk) disable iff (srst)
		!run |=> !hi_flag && !lo_flag) // R14
		else $error("flags set while stopped");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		run && !avg_vld ##1 run |-> $stable(hi_flag) && $stable(lo_flag)) // R13
		else $error("flags changed without an average");
	COV_HI: cover property (@(posedge clk) disable iff (srst) $rose(hi_flag));
	COV_LO: cover property (@(posedge clk) disable iff (srst) $rose(lo_flag));
endmodule : tmn_cmp

// ### tmn_pkg.sv
// Package for the temperature monitor block: register map, fields, resets.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package tmn_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_AVG_CFG   = 8'h00; // temp_avg_config
	localparam logic [7:0] OFF_INT_HI    = 8'h04; // internal_high_limit
	localparam logic [7:0] OFF_INT_LO    = 8'h08; // internal_low_limit
	localparam logic [7:0] OFF_E1_HI     = 8'h0c; // ext_one_high_limit
	localparam logic [7:0] OFF_E1_LO     = 8'h10; // ext_one_low_limit
	localparam logic [7:0] OFF_E2_HI     = 8'h14; // ext_two_high_limit
	localparam logic [7:0] OFF_E2_LO     = 8'h18; // ext_two_low_limit
	localparam logic [7:0] OFF_CTRL      = 8'h1c; // monitor_enables, overheat enable
	localparam logic [7:0] OFF_FLAGS     = 8'h20; // alarm flags, live
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h24; // sticky events, write one to clear
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h28; // interrupt mask
	// Field positions
	localparam int CTRL_EN_LSB   = 8;   // monitor_enables[2:0] at bits 10:8
	localparam int CTRL_OVH_BIT  = 7;   // overheat_reset_enable
	localparam int FLAG_HI_BIT   = 2;   // high alarm in each flag nibble
	localparam int FLAG_LO_BIT   = 1;   // low alarm in each flag nibble
	localparam int FLAG_STRIDE   = 4;   // nibble per sensor in flags register
	// Reset values
	localparam logic [15:0] RST_AVG_CFG = 16'h0000;
	localparam logic [11:0] RST_HI      = 12'h7ff;
	localparam logic [11:0] RST_LO      = 12'h800;
	localparam logic [15:0] RST_CTRL    = 16'h0000;
	// Overheat trip: 145 degrees in 0.125 degree steps
	localparam int          OVH_DEG     = 145;
	localparam logic [11:0] OVH_CODE    = 12'(OVH_DEG * 8);
	// Sensor count
	localparam int NSENS = 3;
endpackage : tmn_pkg

// ### tmn_sensor_model.sv
// Sensor front-end model: sends strobed signed samples for one sensor at a time.
// Assumes the block samples SMP_VLD and SMP_DATA on the rising edge of clk.
module tmn_sensor_model
	import tmn_pkg::*;
#(
	parameter int W = 12
) (
	// Clock
	input  wire logic          clk,
	// Sample strobes and data
	output logic [NSENS-1:0]   vld,
	output logic [NSENS*W-1:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	int           cnt  = 0;  // Samples still to send
	int           gap  = 0;  // Idle cycles before the next strobe
	int           sel  = 0;  // Sensor lane in use
	logic         slow = 0;  // Spread strobes three cycles apart
	logic [W-1:0] val  = '0; // Sample value, two's complement

	// Put the sample on its lane, keep the others moving
	function automatic logic [NSENS*W-1:0] lane(input logic [NSENS*W-1:0] b);
		b[sel*W +: W] = val;
		return b;
	endfunction : lane

	initial
	begin
		vld = '0;
		data = '0;
	end

	// Idle data toggles each cycle, so stale values never pass for a sample
	always @(posedge clk)
	begin
		if (cnt > 0 && gap == 0)
		begin
			vld <= NSENS'(1) << sel;
			data <= lane(~data);
			cnt <= cnt - 1;
			gap <= slow ? 2 : 0;
		end
		else
		begin
			vld <= '0;
			data <= ~data;
			gap <= (gap > 0) ? gap - 1 : 0;
		end
	end

	// Send n samples of value v on sensor g and wait until they are out
	task automatic feed(input int g, input logic [W-1:0] v, input int n, input logic s);
		@(posedge clk);
		sel <= g;
		val <= v;
		slow <= s;
		cnt <= n;
		do @(posedge clk); while (cnt != 0);
		@(posedge clk);
	endtask : feed
endmodule : tmn_sensor_model

// ### tmn_testbench.sv
// Self-checking bench for the temperature monitor top.
// Assumes one AHB-Lite slave whose HREADYOUT is the bus ready.
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tmn_pkg::*;
	logic        CLOCK = 0;
	logic        SRST  = 1;
	logic        HSEL  = 0;
	logic        HWRITE = 0;
	logic [31:0] HADDR  = '0;
	logic [31:0] HWDATA = '0;
	logic [1:0]  HTRANS = '0;
	logic [2:0]  HSIZE  = 3'h2; // Whole words only
	logic [31:0] HRDATA;
	logic        HREADYOUT, HRESP, OVERHEAT_RESET, IRQ;
	logic [2:0]  HI_ALARM, LO_ALARM, SMP_VLD;
	logic [35:0] SMP_DATA;
	int          num_errors = 0;
	int          compares = 0;
	int          ovh_n = 0;          // Overheat pulses seen
	logic [31:0] seed = 32'h7ee5d765;
	logic        rd_ph = 0;          // Read data phase in progress
	logic        pt_go = 0;          // Port check due
	logic [31:0] rd_q[$], rm_q[$];   // Expected read data and masks
	logic [6:0]  pt_q[$];            // Expected {HI, LO, IRQ}

	always #50 CLOCK = ~CLOCK;

	tmn_top dut (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SMP_VLD(SMP_VLD),
		.SMP_DATA(SMP_DATA), .HI_ALARM(HI_ALARM), .LO_ALARM(LO_ALARM),
		.OVERHEAT_RESET(OVERHEAT_RESET), .IRQ(IRQ));
	tmn_sensor_model sm (.clk(CLOCK), .vld(SMP_VLD), .data(SMP_DATA));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task complete_run;
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// One single transfer; holds each phase until ready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= 32'(a);
		do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		rd_ph <= !w;
		do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
		rd_ph <= 1'b0;
		HSEL <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		rd_q.push_back(e & m);
		rm_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic pchk(input logic [2:0] h, input logic [2:0] l, input logic i);
		pt_q.push_back({h, l, i});
		@(posedge CLOCK);
		pt_go <= 1'b1;
		@(posedge CLOCK);
		pt_go <= 1'b0;
	endtask : pchk

	// Watcher: read data at the closing edge of the data phase, ports on request
	always @(posedge CLOCK)
	begin
		if (OVERHEAT_RESET === 1'b1)
			ovh_n++;
		if (rd_ph && HREADYOUT === 1'b1)
		begin
			`CHK(HRDATA & rm_q[0], rd_q[0])
			`CHK(HRESP, 1'b0)
			rd_q.pop_front();
			rm_q.pop_front();
		end
		if (pt_go)
		begin
			`CHK({HI_ALARM, LO_ALARM, IRQ}, pt_q[0])
			pt_q.pop_front();
		end
	end

	// Watchdog, far beyond the roughly 1400 cycles the tests need
	initial
	begin
		#5000000;
		num_errors++;
		complete_run();
	end

	initial
	begin
		logic [11:0] lim, val;
		logic [7:0]  la;
		logic        hi;
		int          n;
		repeat (20) @(posedge CLOCK);
		SRST <= 1'b0;
		// Reset values, then an unmapped slot that ignores writes
		rd(OFF_AVG_CFG, 32'(RST_AVG_CFG), 32'h3f);
		for (int g = 0; g < 3; g++)
		begin
			rd(OFF_INT_HI + 8'(8 * g), 32'(RST_HI), 32'hfff);
			rd(OFF_INT_LO + 8'(8 * g), 32'(RST_LO), 32'hfff);
		end
		rd(OFF_CTRL, 32'(RST_CTRL), 32'h780);
		rd(OFF_FLAGS, 32'h0, 32'hfff);
		wr(8'h2c, 32'hffffffff);
		rd(8'h2c, 32'h0, 32'hffffffff);
		// Every sensor, every count code; signs chosen so unsigned compare would fail
		for (int g = 0; g < 3; g++)
			for (int c = 0; c < 4; c++)
			begin
				n = 4 << c;
				hi = c[0] ^ g[0];
				lim = hi ? -(12'(xs() % 500) + 12'h1) : 12'(xs() % 500);
				val = hi ? 12'(xs() % 500) : -(12'(xs() % 500) + 12'h1);
				la = OFF_INT_HI + 8'(8 * g) + (hi ? 8'h0 : 8'h4);
				wr(OFF_IRQ_MASK, (c == 3) ? 32'h0 : 32'h3f);
				wr(OFF_AVG_CFG, 32'(c) << (2 * g));
				wr(OFF_INT_HI + 8'(8 * g), hi ? 32'(lim) : 32'(RST_HI));
				wr(OFF_INT_LO + 8'(8 * g), hi ? 32'(RST_LO) : 32'(lim));
				rd(la, 32'(lim), 32'hfff);
				wr(OFF_CTRL, 32'h100 << g);
				sm.feed(g, val, n - 1, c[1]);
				repeat (4) @(posedge CLOCK);
				pchk(3'h0, 3'h0, 1'b0);
				sm.feed(g, val, 1, 1'b0);
				repeat (4) @(posedge CLOCK);
				pchk(3'(hi) << g, 3'(!hi) << g, c != 3);
				rd(OFF_FLAGS, 32'h1 << (FLAG_STRIDE * g + (hi ? FLAG_HI_BIT : FLAG_LO_BIT)),
					32'hfff);
				rd(OFF_IRQ_STAT, 32'h1 << (g + (hi ? 0 : 3)), 32'h3f);
				wr(OFF_IRQ_STAT, 32'h3f);
				rd(OFF_IRQ_STAT, 32'h0, 32'h3f);
				wr(OFF_CTRL, 32'h0);
				sm.feed(g, val, n, 1'b0);
				repeat (4) @(posedge CLOCK);
				pchk(3'h0, 3'h0, 1'b0);
			end
		// Overheat: the trip code itself holds, one step above resets the registers but not the output flops
		wr(OFF_AVG_CFG, 32'h0);
		wr(OFF_CTRL, 32'h181);
		sm.feed(0, OVH_CODE, 4, 1'b0);
		repeat (4) @(posedge CLOCK);
		`CHK(ovh_n, 0)
		sm.feed(0, 12'(OVH_CODE + 1), 4, 1'b0);
		repeat (4) @(posedge CLOCK);
		`CHK(ovh_n, 1)
		rd(OFF_CTRL, 32'(RST_CTRL), 32'h780);
		rd(OFF_INT_HI, 32'(RST_HI), 32'hfff);
		complete_run();
	end
endmodule : testbench

// ### tmn_top.sv
// Temperature monitor: three averaged sensors, threshold alarms, overheat reset.
// Assumes AHB-Lite single-word accesses and synchronous sample strobes.
// Overview of operation
// (R1) Internal average count from config bits 1:0
// (R2) First external count from config bits 3:2
// (R3) Second external count from config bits 5:4
// (R4) Internal above high limit sets bit 2
// (R5) Internal below low limit sets bit 1
// (R6) External one above high sets bit 2
// (R7) External one below low sets bit 1
// (R8) External two above high sets bit 2
// (R9) External two below low sets bit 1
// (R10) Limits signed twelve bit, eighth-degree steps
// (R11) Each monitor runs only when enabled
// (R12) Internal above 145 degrees resets all registers; the output flops are reset by SRST only
// (R13) Compare only completed averages, once each
// (R14) Disabled monitor keeps its alarms clear
//
// Our own choices: the register offsets and the AHB-Lite slave port.
module tmn_top
	import tmn_pkg::*;
#(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic                CLOCK,
	input  wire logic                SRST,
	// AHB-Lite slave
	input  wire logic                HSEL,
	input  wire logic [31:0]         HADDR,
	input  wire logic [1:0]          HTRANS,
	input  wire logic                HWRITE,
	input  wire logic [2:0]          HSIZE,
	input  wire logic [31:0]         HWDATA,
	input  wire logic                HREADY,
	output logic      [31:0]         HRDATA,
	output logic                     HREADYOUT,
	output logic                     HRESP,
	// Sensor samples, one strobe per sensor
	input  wire logic [NSENS-1:0]    SMP_VLD,
	input  wire logic [NSENS*W-1:0]  SMP_DATA,
	// Status outputs
	output logic      [NSENS-1:0]    HI_ALARM,
	output logic      [NSENS-1:0]    LO_ALARM,
	output logic                     OVERHEAT_RESET,
	output logic                     IRQ
);
	import tmn_pkg::*;

	// Software registers
	logic [15:0]        avg_cfg_reg;   // Averaging depths
	logic [W-1:0]       hi_lim_reg [NSENS]; // High limits per sensor
	logic [W-1:0]       lo_lim_reg [NSENS]; // Low limits per sensor
	logic [15:0]        ctrl_reg;      // Enables and overheat enable
	logic [5:0]         irq_stat_reg;  // Sticky alarm rises
	logic [5:0]         irq_mask_reg;  // Interrupt mask
	// AHB data-phase capture
	logic               wr_pend_reg;   // A write data phase is due
	logic [7:0]         wr_addr_reg;   // Its address
	// Internal results
	logic [NSENS-1:0]   avg_vld;       // Average complete strobes
	logic [W-1:0]       avg [NSENS];   // Averages
	logic [NSENS-1:0]   hi_flag;       // High alarms
	logic [NSENS-1:0]   lo_flag;       // Low alarms
	logic [NSENS-1:0]   hi_prev_reg;   // Previous alarms for edge events
	logic [NSENS-1:0]   lo_prev_reg;
	logic               ovh_trip;      // Overheat condition
	logic               soft_rst;      // Internal reset request
	logic               rst_all;       // Combined reset
	// Decode
	logic               req;           // Valid transfer taken
	logic               rd_req;
	logic [7:0]         rd_addr;
	logic [31:0]        rd_data;
	logic [NSENS-1:0]   run;           // Monitor enables
	logic [15:0]        flags_word;    // Flags readout
	logic [5:0]         evt;           // Rising alarm events
	logic [31:0]        wdata;

	assign req      = HSEL && HREADY && HTRANS[1];
	assign rd_req   = req && !HWRITE;
	assign rd_addr  = HADDR[7:0];
	assign run      = ctrl_reg[CTRL_EN_LSB +: NSENS]; // R11
	assign wdata    = HWDATA;
	assign rst_all  = SRST || soft_rst;
	assign evt      = {lo_flag & ~lo_prev_reg, hi_flag & ~hi_prev_reg};

	// Overheat: internal average above 145 degrees while enabled
	assign ovh_trip = ctrl_reg[CTRL_OVH_BIT] && run[0] && avg_vld[0]
		&& ($signed(avg[0]) > $signed(OVH_CODE)); // R12

	// One averager and comparator per sensor
	genvar g;
	generate
		for (g = 0; g < NSENS; g++)
		begin : g_sens
			tmn_avg #(.W(W)) u_avg (
				.clk     (CLOCK),
				.srst    (rst_all),
				.run     (run[g]),                  // R11
				.sel     (avg_cfg_reg[2*g +: 2]),   // R1 R2 R3
				.smp_vld (SMP_VLD[g]),
				.smp     (SMP_DATA[g*W +: W]),
				.avg_vld (avg_vld[g]),
				.avg     (avg[g])
			);
			tmn_cmp #(.W(W)) u_cmp (
				.clk     (CLOCK),
				.srst    (rst_all),
				.run     (run[g]),
				.hi_lim  (hi_lim_reg[g]),
				.lo_lim  (lo_lim_reg[g]),
				.avg_vld (avg_vld[g]),
				.avg     (avg[g]),
				.hi_flag (hi_flag[g]),
				.lo_flag (lo_flag[g])
			);
			assign flags_word[g*FLAG_STRIDE +: FLAG_STRIDE] =
				{1'b0, hi_flag[g], lo_flag[g], 1'b0};
		end
	endgenerate
	assign flags_word[15:NSENS*FLAG_STRIDE] = '0;

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		case (rd_addr)
			OFF_AVG_CFG:  rd_data = {16'h0, avg_cfg_reg};
			OFF_INT_HI:   rd_data = {20'h0, hi_lim_reg[0]};
			OFF_INT_LO:   rd_data = {20'h0, lo_lim_reg[0]};
			OFF_E1_HI:    rd_data = {20'h0, hi_lim_reg[1]};
			OFF_E1_LO:    rd_data = {20'h0, lo_lim_reg[1]};
			OFF_E2_HI:    rd_data = {20'h0, hi_lim_reg[2]};
			OFF_E2_LO:    rd_data = {20'h0, lo_lim_reg[2]};
			OFF_CTRL:     rd_data = {16'h0, ctrl_reg};
			OFF_FLAGS:    rd_data = {16'h0, flags_word};
			OFF_IRQ_STAT: rd_data = {26'h0, irq_stat_reg};
			OFF_IRQ_MASK: rd_data = {26'h0, irq_mask_reg};
			default:      rd_data = 32'h0;
		endcase
	end

	// Overheat reset pulse, registered; next cycle it resets every register except the output flops
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			soft_rst <= 1'b0;
		else
			soft_rst <= ovh_trip && !soft_rst; // R12
	end

	// Address phase capture for writes; reads are answered in the data phase
	always_ff @(posedge CLOCK)
	begin
		if (rst_all)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			HRDATA      <= 32'h0;
		end
		else
		begin
			wr_pend_reg <= req && HWRITE;
			wr_addr_reg <= HADDR[7:0];
			if (rd_req)
				HRDATA <= rd_data;
		end
	end

	// Software writes; a trip resets every register to default (R12)
	always_ff @(posedge CLOCK)
	begin
		if (rst_all)
		begin
			avg_cfg_reg <= RST_AVG_CFG;
			ctrl_reg    <= RST_CTRL;
			for (int i = 0; i < NSENS; i++)
			begin
				hi_lim_reg[i] <= RST_HI;
				lo_lim_reg[i] <= RST_LO;
			end
			irq_mask_reg <= 6'h00;
		end
		else if (wr_pend_reg)
		begin
			case (wr_addr_reg)
				OFF_AVG_CFG:  avg_cfg_reg   <= {10'h0, wdata[5:0]};
				OFF_INT_HI:   hi_lim_reg[0] <= wdata[W-1:0];
				OFF_INT_LO:   lo_lim_reg[0] <= wdata[W-1:0];
				OFF_E1_HI:    hi_lim_reg[1] <= wdata[W-1:0];
				OFF_E1_LO:    lo_lim_reg[1] <= wdata[W-1:0];
				OFF_E2_HI:    hi_lim_reg[2] <= wdata[W-1:0];
				OFF_E2_LO:    lo_lim_reg[2] <= wdata[W-1:0];
				OFF_CTRL:     ctrl_reg      <= {5'h0, wdata[10:7], 7'h0};
				OFF_IRQ_MASK: irq_mask_reg  <= wdata[5:0];
				default:      ;
			endcase
		end
	end

	// Sticky events: a new rise beats a write-one clear in the same cycle
	always_ff @(posedge CLOCK)
	begin
		if (rst_all)
		begin
			irq_stat_reg <= 6'h00;
			hi_prev_reg  <= '0;
			lo_prev_reg  <= '0;
		end
		else
		begin
			hi_prev_reg  <= hi_flag;
			lo_prev_reg  <= lo_flag;
			if (wr_pend_reg && wr_addr_reg == OFF_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~wdata[5:0]) | evt;
			else
				irq_stat_reg <= irq_stat_reg | evt;
		end
	end

	// Outputs straight from flops
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			HI_ALARM       <= '0;
			LO_ALARM       <= '0;
			OVERHEAT_RESET <= 1'b0;
			IRQ            <= 1'b0;
		end
		else
		begin
			HI_ALARM       <= hi_flag;
			LO_ALARM       <= lo_flag;
			OVERHEAT_RESET <= soft_rst;
			IRQ            <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Zero wait states and OKAY response always
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	AST_TRIP_RESET: assert property (@(posedge CLOCK) disable iff (SRST)
		ovh_trip && !soft_rst |=> soft_rst ##1 (ctrl_reg == RST_CTRL)) // R12
		else $error("overheat did not reset registers");
	AST_RUN_EN: assert property (@(posedge CLOCK) disable iff (SRST)
		!ctrl_reg[CTRL_EN_LSB] |-> !avg_vld[0] ##1 !hi_flag[0]) // R11
		else $error("internal monitor ran while disabled");
	AST_CFG_SEL: assert property (@(posedge CLOCK) disable iff (SRST)
		wr_pend_reg && !soft_rst && wr_addr_reg == OFF_AVG_CFG
		|=> avg_cfg_reg[5:0] == $past(wdata[5:0])) // R1
		else $error("average depth not stored");
	AST_SIGNED: assert property (@(posedge CLOCK) disable iff (rst_all)
		run[1] && avg_vld[1] && $signed(avg[1]) < $signed(lo_lim_reg[1])
		##1 run[1] && !soft_rst |-> lo_flag[1]) // R10
		else $error("signed low compare failed");
	COV_TRIP: cover property (@(posedge CLOCK) disable iff (SRST) soft_rst);
	COV_IRQ: cover property (@(posedge CLOCK) disable iff (SRST) $rose(IRQ));
endmodule : tmn_top
